//--- logic/call_clear_cfg.svh
// Purpose: Constants of the long-call and clear-file execution block.
// Assumes: Included by bare name; definitions only.
// Notes: Widths, offsets, encodings and reset values live here.
`ifndef CALL_CLEAR_CFG_SVH
`define CALL_CLEAR_CFG_SVH

`define INSTR_W 16
`define PC_W 21
`define DATA_W 8
`define DADDR_W 12
`define FLAGS_W 5
`define BSR_W 4
`define OPC_W 7
`define CALL_OPC 7'h76
`define ZERO_FILE_REGISTER_OP_OPC 7'h35
`define NOP_WORD 16'h0000
`define PC_STEP 21'h000002
`define RET_ADJ 21'h000002
`define Z_BIT 2
`define Z_MASK 5'h04
`define IDX_LIMIT 8'h5F
`define ACCESS_HI_BANK 4'hF
`define ACCESS_LO_BANK 4'h0
`define STACK_DEPTH 16
`define SP_W 5
`define PC_RESET 21'h000000
`define REG8_RESET 8'h00
`define FLAGS_RESET 5'h00
`define BSR_RESET 4'h0
`define SP_RESET 5'h00

`endif

//--- logic/call_clear_pkg.sv
// Purpose: Types shared by the long-call and clear-file execution block.
// Assumes: Constants come from call_clear_cfg.svh.
// Notes: Encodings follow Gray order along the usual path.
`include "call_clear_cfg.svh"
package call_clear_pkg;
  typedef enum logic [1:0] {
    OP_OTHER = 2'b00,
    OP_CALL = 2'b01,
    OP_ZERO_FILE_REGISTER_OP = 2'b11
  } op_type;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_CALL_NOP = 1'b1
  } exec_state_type;

  typedef logic [`PC_W-1:0] pc_type;
  typedef logic [`DADDR_W-1:0] daddr_type;
endpackage : call_clear_pkg

//--- logic/quarter_phase_gen.sv
// Purpose: Divides the core clock into four quarter-phase enables.
// Assumes: One instruction cycle is four core clocks.
// Notes: Exactly one enable is high in every clock after reset.
`timescale 1ns/1ns
module quarter_phase_gen (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Phase enables.
  output logic q1_en_out,
  output logic q2_en_out,
  output logic q3_en_out,
  output logic q4_en_out
);
  logic [1:0] phase_r;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign q1_en_out = (phase_r == 2'h0);
  assign q2_en_out = (phase_r == 2'h1);
  assign q3_en_out = (phase_r == 2'h2);
  assign q4_en_out = (phase_r == 2'h3);
endmodule : quarter_phase_gen

//--- logic/call_and_clear_instr_exec.sv
// Purpose: Executes the long subroutine call and the clear-file instruction.
// Assumes: Program memory answers within the cycle; word sampled in Q4.
// Notes: Working, flag and bank-select values are owned by the datapath outside.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "call_clear_cfg.svh"

module call_and_clear_instr_exec (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Program memory.
  output call_clear_pkg::pc_type prog_addr_out,
  input wire logic [`INSTR_W-1:0] prog_data_in,
  // Core registers owned by the datapath.
  input wire logic [`DATA_W-1:0] working_in,
  input wire logic [`FLAGS_W-1:0] flags_in,
  input wire logic [`BSR_W-1:0] bank_select_reg_in,
  input wire logic ext_set_en_in,
  input wire call_clear_pkg::daddr_type index_base_in,
  // Data memory.
  output call_clear_pkg::daddr_type data_addr_out,
  output logic data_rd_out,
  output logic data_wr_out,
  output logic [`DATA_W-1:0] data_wdata_out,
  // Flag write-back.
  output logic flags_wr_out,
  output logic [`FLAGS_W-1:0] flags_wdata_out,
  // Shadows, stack and counter.
  output logic [`DATA_W-1:0] working_shadow_out,
  output logic [`FLAGS_W-1:0] flags_shadow_out,
  output logic [`BSR_W-1:0] bank_select_shadow_out,
  output call_clear_pkg::pc_type return_stack_top_out,
  output logic stack_full_out,
  output call_clear_pkg::pc_type pc_out
);
  import call_clear_pkg::*;

  logic q1_en;
  logic q2_en;
  logic q3_en;
  logic q4_en;
  pc_type pc_r;
  logic [`INSTR_W-1:0] ir_r;
  exec_state_type state_r;
  logic [7:0] k_lo_r;
  op_type cur_op;
  logic [`SP_W-1:0] sp_r;
  pc_type stack_mem [`STACK_DEPTH];
  daddr_type data_addr_r;
  logic data_rd_r;
  logic data_wr_r;
  logic flags_wr_r;
  logic [`FLAGS_W-1:0] flags_wdata_r;
  logic [`DATA_W-1:0] working_shadow_r;
  logic [`FLAGS_W-1:0] flags_shadow_r;
  logic [`BSR_W-1:0] bank_select_shadow_r;
  logic do_call;
  logic do_zero_file_register_op;

  // Opcode classification from the upper seven bits.
  function automatic op_type decode_op(input logic [`INSTR_W-1:0] word);
    op_type op;
    op = OP_OTHER;
    if (word[15:9] == `CALL_OPC) begin
      op = OP_CALL;
    end else if (word[15:9] == `ZERO_FILE_REGISTER_OP_OPC) begin
      op = OP_ZERO_FILE_REGISTER_OP;
    end
    return op;
  endfunction : decode_op

  // Effective data address of a file operand.
  function automatic daddr_type file_addr(input logic sel_bank, input logic [7:0] f,
                                          input logic [`BSR_W-1:0] bank_select_reg, input logic ext,
                                          input daddr_type base);
    daddr_type addr;
    if (sel_bank) begin
      addr = {bank_select_reg, f};
    end else if (ext && (f <= `IDX_LIMIT)) begin
      addr = base + {4'h0, f};
    end else if (f <= `IDX_LIMIT) begin
      addr = {`ACCESS_LO_BANK, f};
    end else begin
      addr = {`ACCESS_HI_BANK, f};
    end
    return addr;
  endfunction : file_addr

  quarter_phase_gen u_phase (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .q1_en_out(q1_en),
    .q2_en_out(q2_en),
    .q3_en_out(q3_en),
    .q4_en_out(q4_en)
  );

  // The word held in the instruction register is executed only in the run state.
  assign cur_op = decode_op(ir_r);
  assign do_call = (state_r == ST_RUN) && (cur_op == OP_CALL);
  assign do_zero_file_register_op = (state_r == ST_RUN) && (cur_op == OP_ZERO_FILE_REGISTER_OP);

  // Fetch: the word at the counter is latched in Q4, flushed after a call.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_r <= `NOP_WORD;
    end else if (q4_en) begin
      if (do_call) begin
        ir_r <= `NOP_WORD;
      end else begin
        ir_r <= prog_data_in;
      end
    end
  end

  // Program counter: steps one word per cycle, or takes the call target.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_r <= `PC_RESET;
    end else if (q4_en) begin
      if (do_call) begin
        pc_r <= {prog_data_in[11:0], k_lo_r, 1'b0};
      end else begin
        pc_r <= pc_r + `PC_STEP;
      end
    end
  end

  // Low target byte is read from the first word in Q2.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      k_lo_r <= `REG8_RESET;
    end else if (q2_en && do_call) begin
      k_lo_r <= ir_r[7:0];
    end
  end

  // Sequencer: the cycle after a call executes nothing.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_RUN;
    end else if (q4_en) begin
      unique case (state_r)
        ST_RUN: begin
          if (cur_op == OP_CALL) begin
            state_r <= ST_CALL_NOP;
          end
        end
        ST_CALL_NOP: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // Return stack push in Q3; the counter still points at the second word, so two is added.
  // A push into a full stack is dropped so older entries stay intact.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sp_r <= `SP_RESET;
    end else if (q3_en && do_call && !stack_full_out) begin
      sp_r <= sp_r + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (q3_en && do_call && !stack_full_out) begin
      stack_mem[sp_r[3:0]] <= pc_r + `RET_ADJ;
    end
  end

  assign stack_full_out = (sp_r == 5'(`STACK_DEPTH));
  assign return_stack_top_out = (sp_r == `SP_RESET) ? `PC_RESET : stack_mem[4'(sp_r - 5'h01)];

  // Shadow copies are taken in Q3 of a call whose bit 8 is set, even when the push is dropped.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      working_shadow_r <= `REG8_RESET;
      flags_shadow_r <= `FLAGS_RESET;
      bank_select_shadow_r <= `BSR_RESET;
    end else if (q3_en && do_call && ir_r[8]) begin
      working_shadow_r <= working_in;
      flags_shadow_r <= flags_in;
      bank_select_shadow_r <= bank_select_reg_in;
    end
  end

  // Clear-file: read in Q2, write zero in Q4; strobes appear one clock later.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_addr_r <= '0;
    end else if (q2_en && do_zero_file_register_op) begin
      data_addr_r <= file_addr(ir_r[8], ir_r[7:0], bank_select_reg_in,
                               ext_set_en_in, index_base_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_rd_r <= 1'b0;
      data_wr_r <= 1'b0;
    end else begin
      data_rd_r <= q2_en && do_zero_file_register_op;
      data_wr_r <= q4_en && do_zero_file_register_op;
    end
  end

  // Only the zero flag is forced; the rest pass through unchanged.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_wr_r <= 1'b0;
      flags_wdata_r <= `FLAGS_RESET;
    end else begin
      flags_wr_r <= q4_en && do_zero_file_register_op;
      if (q4_en && do_zero_file_register_op) begin
        flags_wdata_r <= flags_in | `Z_MASK;
      end
    end
  end

  assign prog_addr_out = pc_r;
  assign pc_out = pc_r;
  assign data_addr_out = data_addr_r;
  assign data_rd_out = data_rd_r;
  assign data_wr_out = data_wr_r;
  assign data_wdata_out = `REG8_RESET;
  assign flags_wr_out = flags_wr_r;
  assign flags_wdata_out = flags_wdata_r;
  assign working_shadow_out = working_shadow_r;
  assign flags_shadow_out = flags_shadow_r;
  assign bank_select_shadow_out = bank_select_shadow_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence call_tail_s;
    (state_r == ST_CALL_NOP)[*4] ##1 (state_r == ST_RUN);
  endsequence

  sequence zero_file_register_op_steps_s;
    ##2 (data_rd_out && !data_wr_out) ##2 (data_wr_out && !data_rd_out);
  endsequence

  call_push_a: assert property (
    (q3_en && do_call && !stack_full_out) |=>
      (return_stack_top_out == $past(pc_r) + `RET_ADJ))
    else $error("Return address pushed is not call address plus four.");

  shadow_save_a: assert property (
    (q3_en && do_call && ir_r[8]) |=>
      (working_shadow_out == $past(working_in)) && (flags_shadow_out == $past(flags_in))
      && (bank_select_shadow_out == $past(bank_select_reg_in)))
    else $error("Shadow copies not taken on call with save bit set.");

  shadow_hold_a: assert property (
    (q3_en && !(do_call && ir_r[8])) |=>
      $stable(working_shadow_out) && $stable(flags_shadow_out)
      && $stable(bank_select_shadow_out))
    else $error("Shadow copies changed without a saving call.");

  call_target_a: assert property (
    (q4_en && do_call) |=>
      (pc_out == {$past(prog_data_in[11:0]), $past(k_lo_r), 1'b0}) && !pc_out[0])
    else $error("Counter not loaded with call target.");

  call_two_cycle_a: assert property (
    (q4_en && do_call) |=> call_tail_s)
    else $error("Call second cycle is not exactly one idle cycle.");

  call_idle_a: assert property (
    (state_r == ST_CALL_NOP) |=> !data_wr_out && !flags_wr_out)
    else $error("Work done in the idle cycle of a call.");

  clear_write_a: assert property (
    (q4_en && do_zero_file_register_op) |=> data_wr_out && (data_wdata_out == 8'h00) && flags_wr_out
      && (flags_wdata_out == ($past(flags_in) | `Z_MASK)))
    else $error("Clear-file did not write zero and set only the zero flag.");

  bank_select_a: assert property (
    (q2_en && do_zero_file_register_op && ir_r[8]) |=>
      (data_addr_out == {$past(bank_select_reg_in), $past(ir_r[7:0])}))
    else $error("Banked operand address wrong.");

  access_bank_a: assert property (
    (q2_en && do_zero_file_register_op && !ir_r[8] && !(ext_set_en_in && ir_r[7:0] <= `IDX_LIMIT)) |=>
      (data_addr_out[7:0] == $past(ir_r[7:0]))
      && (data_addr_out[11:8] == (($past(ir_r[7:0]) <= `IDX_LIMIT) ? 4'h0 : 4'hF)))
    else $error("Access bank address wrong.");

  indexed_a: assert property (
    (q2_en && do_zero_file_register_op && !ir_r[8] && ext_set_en_in && ir_r[7:0] <= `IDX_LIMIT) |=>
      (data_addr_out == $past(index_base_in) + {4'h0, $past(ir_r[7:0])}))
    else $error("Indexed literal offset address wrong.");

  clear_cycle_a: assert property (
    (q1_en && do_zero_file_register_op) |-> zero_file_register_op_steps_s)
    else $error("Clear-file read and write not in one instruction cycle.");
endmodule : call_and_clear_instr_exec

//--- sim/prog_mem_model.sv
// Purpose: Program memory model that answers the fetches of the execution block.
// Assumes: Words are indexed by byte address bits 20:1; the bench fills mem.
// Notes: Registered read; unwritten words read as NOP so stray fetches do nothing.
`timescale 1ns/1ns
`include "call_clear_cfg.svh"
module prog_mem_model (
  // Fetch port.
  input wire logic clk_in,
  input wire call_clear_pkg::pc_type addr_in,
  output logic [`INSTR_W-1:0] data_out
);
  import call_clear_pkg::*;
  logic [`INSTR_W-1:0] mem [int unsigned];
  always @(posedge clk_in) begin
    data_out <= mem.exists(addr_in[`PC_W-1:1]) ? mem[addr_in[`PC_W-1:1]] : `NOP_WORD;
  end
endmodule : prog_mem_model

//--- sim/call_and_clear_instr_exec_tb.sv
// Purpose: Self-checking bench for the long-call and clear-file execution block.
// Assumes: Two runs, extended set on then off, each after its own reset.
// Notes: Calls are checked one clock after the stack top moves.
`timescale 1ns/1ns
`include "call_clear_cfg.svh"
module call_and_clear_instr_exec_tb;
  import call_clear_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  pc_type prog_addr, pc, rst_top, rst_prev;
  logic [15:0] prog_data;
  logic [7:0] working = 8'h00;
  logic [4:0] flags = 5'h00;
  logic [3:0] bank_select_reg = 4'h0;
  logic ext_en = 1'b0;
  daddr_type base = '0;
  daddr_type data_addr;
  logic [7:0] ws, data_wdata;
  logic [4:0] fs, flags_wdata;
  logic [3:0] bs;
  logic data_rd, data_wr, flags_wr, stack_full;
  logic push_seen = 1'b0;
  logic rd_seen = 1'b0;
  logic [63:0] exp_q [$];
  int miscompares = 0;
  int compares = 0;

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  prog_mem_model u_mem (.clk_in(sys_clk_in), .addr_in(prog_addr), .data_out(prog_data));

  call_and_clear_instr_exec u_dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .prog_addr_out(prog_addr), .prog_data_in(prog_data),
    .working_in(working), .flags_in(flags), .bank_select_reg_in(bank_select_reg),
    .ext_set_en_in(ext_en), .index_base_in(base),
    .data_addr_out(data_addr), .data_rd_out(data_rd), .data_wr_out(data_wr),
    .data_wdata_out(data_wdata), .flags_wr_out(flags_wr), .flags_wdata_out(flags_wdata),
    .working_shadow_out(ws), .flags_shadow_out(fs), .bank_select_shadow_out(bs),
    .return_stack_top_out(rst_top), .stack_full_out(stack_full), .pc_out(pc)
  );

  task automatic check(input string what, input logic [63:0] got);
    logic [63:0] want;
    compares++;
    want = (exp_q.size() == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : exp_q.pop_front();
    if (got !== want) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, want, got);
    end
  endtask : check

  // Results are compared where they have settled, away from the launching edge.
  always @(negedge sys_clk_in) begin
    if (!reset_n_in) begin
      rst_prev = rst_top;
      push_seen = 1'b0;
      rd_seen = 1'b0;
    end else begin
      if (push_seen) check("call", {5'h08, pc, rst_top, ws, fs, bs});
      push_seen = (rst_top !== rst_prev);
      rst_prev = rst_top;
      if (data_rd === 1'b1) rd_seen = 1'b1;
      if (data_wr === 1'b1) begin
        check("clear", {37'h0, rd_seen, flags_wr, data_addr, flags_wdata, data_wdata});
        rd_seen = 1'b0;
      end
    end
  end

  // A clear-file result carries the read strobe seen before its write.
  function automatic logic [63:0] clr(input daddr_type a, input logic [4:0] f);
    return {37'h0, 1'b1, 1'b1, a, f | `Z_MASK, 8'h00};
  endfunction : clr

  function automatic daddr_type acc(input logic [7:0] f, input logic ext, input daddr_type b);
    if (ext && f <= 8'h5F) return b + {4'h0, f};
    return {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
  endfunction : acc

  task automatic ld(input pc_type a, input logic [15:0] w);
    u_mem.mem[a[`PC_W-1:1]] = w;
  endtask : ld

  task automatic run(input logic ext);
    logic [7:0] wa, wb, f0;
    logic [4:0] fa, fb;
    logic [3:0] ba, bb;
    daddr_type bz;
    pc_type t1, t2;
    int i;
    wa = 8'($urandom);
    wb = 8'($urandom);
    f0 = 8'($urandom);
    fa = 5'($urandom);
    fb = 5'($urandom);
    ba = 4'($urandom);
    bb = 4'($urandom);
    bz = 12'($urandom);
    t1 = 21'h100020;
    t2 = 21'h000200;
    u_mem.mem.delete();
    ld(21'h0, {8'h6B, f0}); exp_q.push_back(clr({ba, f0}, fa));
    ld(21'h2, 16'h6A5F); exp_q.push_back(clr(acc(8'h5F, ext, bz), fa));
    ld(21'h4, 16'h6A60); exp_q.push_back(clr(acc(8'h60, ext, bz), fa));
    ld(21'h6, 16'h6A00); exp_q.push_back(clr(acc(8'h00, ext, bz), fa));
    ld(21'h8, 16'hED10); ld(21'hA, 16'hF800);
    exp_q.push_back({5'h08, t1, 21'h00000C, wa, fa, ba});
    ld(21'hC, 16'h6BAA);
    ld(t1, 16'hEC00); ld(t1 + 21'h2, 16'hF001);
    exp_q.push_back({5'h08, t2, t1 + 21'h4, wa, fa, ba});
    ld(t1 + 21'h4, 16'h6BAA);
    ld(t2, {8'h6B, f0}); exp_q.push_back(clr({bb, f0}, fb));
    reset_n_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    working <= wa;
    flags <= fa;
    bank_select_reg <= ba;
    ext_en <= ext;
    base <= bz;
    reset_n_in <= 1'b1;
    for (i = 0; i < 200 && pc !== t1; i++) @(posedge sys_clk_in);
    working <= wb;
    flags <= fb;
    bank_select_reg <= bb;
    repeat (80) @(posedge sys_clk_in);
    compares++;
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("wrong value pending expected 0 seen %0d", exp_q.size());
      exp_q.delete();
    end
    compares++;
    if (stack_full !== 1'b0) begin
      miscompares++;
      $display("wrong value stack_full expected 0 seen %b", stack_full);
    end
    $display("test ext=%0d done", ext);
  endtask : run

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    void'($urandom(32'h860CCA83));
    @(posedge sys_clk_in);
    run(1'b1);
    run(1'b0);
    stop_test();
  end
endmodule : call_and_clear_instr_exec_tb
